// >>> bcs_defs.vh
// constants for the six-decade scan-preset counter
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
`define BCS_NDIG 6
`define BCS_CLK_MHZ 40
`define BCS_BLANK_NS 4000
`define BCS_BLANK_CYC ((`BCS_BLANK_NS * `BCS_CLK_MHZ + 999) / 1000)
`define BCS_RAMP_CYC 400
`define BCS_CLR_NS 2000
`define BCS_CLR_CYC ((`BCS_CLR_NS * `BCS_CLK_MHZ + 999) / 1000)
`define BCS_SCANC_NS 30000
`define BCS_SCANC_CYC ((`BCS_SCANC_NS * `BCS_CLK_MHZ) / 1000)
`define BCS_CNT_PERIOD_NS 1000
`define BCS_CNT_MIN_CYC ((`BCS_CNT_PERIOD_NS * `BCS_CLK_MHZ) / 1000)
`define BCS_ZERO_DLY 4
`define BCS_DIG6 6'h20
`define BCS_RST_VALUE 24'h000000
`endif

// >>> bcs_store.v
// six-decade bcd store with per-decade load and registered contents
`timescale 1ns/1ps
`default_nettype none
module bcs_store #(
   parameter NDIG = 6
) (
   // clock and reset
   input wire CLK,
   input wire RST_N,
   // decade load
   input wire ld,
   input wire [NDIG-1:0] ld_sel,
   input wire [3:0] ld_data,
   // contents
   output reg [4*NDIG-1:0] q
);
   integer i;
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= {(4*NDIG){1'b0}};
      end else if (ld) begin
         for (i = 0; i < NDIG; i = i + 1) begin
            if (ld_sel[i]) begin
               q[4*i +: 4] <= ld_data;
            end
         end
      end
   end
endmodule // bcs_store
`default_nettype wire

// >>> bcs_counter.v
// six-decade up/down bcd counter with scan-driven preset and compare
// How it works
// - at most one of six digit strobes is ever high
// - bcd inputs read as zero while blanking, stale slot data cleared
// - pending preset loads the strobed bcd value; strobe 6 is most significant decade
// - every strobe held low during the blanking gap
// - free-running scan uses a fixed internal blanking length
// - external scan adds its low time to the fixed blanking
// - too-short external high time keeps blanking forever, no strobes
// - counter and register presets may run in the same scan cycle
// - counter and register bcd inputs may share one strobed source
// - counting down, match when equal to register, later zero at zero
// - count hold high ignores count pulses, feedback freezes count
// - clear or either preset releases a feedback freeze
// - count pulses accepted up to 1.0 MHz
// - match output is faster than zero output
// - preset latched before strobe rise, data taken at strobe fall, counting blocked
// - scan visits digit 6 down to digit 1
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.vh"
module bcs_counter #(
   parameter NDIG = 6,
   parameter RAMP_CYC = `BCS_RAMP_CYC,
   parameter SCANC_CYC = `BCS_SCANC_CYC
) (
   // clock and reset
   input wire CLK,
   input wire RST_N,
   // scan control
   input wire SCAN_EXT_EN,
   input wire SCAN_IN,
   input wire SCAN_SET,
   output reg [NDIG-1:0] DIGIT,
   output reg BLANKING,
   // preset sources
   input wire [3:0] CNT_BCD,
   input wire [3:0] REG_BCD,
   input wire LOAD_CNT,
   input wire LOAD_REG,
   // counting
   input wire COUNT,
   input wire UP_DN,
   input wire COUNT_HOLD,
   input wire CLEAR,
   input wire STORE,
   input wire LEADING_BLANK_CTRL,
   // results
   output reg [4*NDIG-1:0] COUNT_VAL,
   output reg [3:0] BCD_OUT,
   output reg BCD_OUT_BLANK,
   output reg MATCH,
   output reg ZERO,
   output reg CARRY
);
   localparam [2:0] ST_BLANK = 3'b001;
   localparam [2:0] ST_STROBE = 3'b010;
   localparam [2:0] ST_HOLD = 3'b100;
   localparam [15:0] BLANK_CYC = `BCS_BLANK_CYC;
   localparam [15:0] RAMP = RAMP_CYC;
   localparam [15:0] SCANC = SCANC_CYC;
   localparam [15:0] CNT_MIN = `BCS_CNT_MIN_CYC;
   localparam [15:0] CLR_CYC = `BCS_CLR_CYC;
   // timer runs down to zero inclusive, so load one less
   localparam [15:0] BLANK_LD = BLANK_CYC - 16'h0001;

   // bcd digit step with carry or borrow
   function [4:0] bcd_step;
      input [3:0] d;
      input up;
      begin
         if (up) begin
            bcd_step = (d >= 4'h9) ? {1'b1, 4'h0} : {1'b0, d + 4'h1};
         end else begin
            bcd_step = (d == 4'h0) ? {1'b1, 4'h9} : {1'b0, d - 4'h1};
         end
      end
   endfunction

   reg [2:0] st_r, st_nxt;
   reg [15:0] tmr_r;
   reg [NDIG-1:0] slot_r;
   reg scan_d_r, high_ok_r;
   reg [15:0] high_cnt_r;
   reg ld_cnt_r, ld_reg_r;
   reg [15:0] clr_cnt_r;
   reg count_d_r;
   reg [15:0] gap_r;
   reg [4*NDIG-1:0] latch_r;
   reg [NDIG-1:0] lead_r;
   reg [3:0] zero_sh_r;
   reg [4*NDIG-1:0] nxt_val;
   reg c;
   reg [4:0] s;
   reg [3:0] sel_cnt, sel_reg;
   integer i, j, k;
   wire [4*NDIG-1:0] reg_val;
   wire slot_end;
   wire strobe_fall;
   wire count_edge;
   wire clr_now;
   wire cnt_frozen;

   // external scan: strobe ends as soon as scan is low, even if drive starts mid-slot
   assign slot_end = SCAN_EXT_EN ? ~SCAN_IN : (tmr_r == 16'h0000);
   assign strobe_fall = (st_r == ST_STROBE) & slot_end;

   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_BLANK: begin
            // fixed gap, counted only once external scan is high
            if (tmr_r == 16'h0000 && (!SCAN_EXT_EN || (SCAN_IN && high_ok_r))) begin
               st_nxt = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (slot_end) begin
               st_nxt = ST_BLANK;
            end
         end
         ST_HOLD: begin
            if (!SCAN_SET) begin
               st_nxt = ST_BLANK;
            end
         end
         default: st_nxt = ST_BLANK;
      endcase
      if (SCAN_SET) begin
         st_nxt = ST_HOLD;
      end
   end

   // scan sequencer
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= ST_BLANK;
         tmr_r <= BLANK_LD; // first strobe only after a full gap
         slot_r <= `BCS_DIG6;
         scan_d_r <= 1'b0;
         high_cnt_r <= 16'h0000;
         high_ok_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         scan_d_r <= SCAN_IN;
         // short external high time poisons the blanking circuit
         if (SCAN_EXT_EN && SCAN_IN) begin
            if (high_cnt_r != 16'hFFFF) begin
               high_cnt_r <= high_cnt_r + 16'h0001;
            end
         end else begin
            high_cnt_r <= 16'h0000;
         end
         if (!SCAN_EXT_EN) begin
            high_ok_r <= 1'b1;
         end else if (scan_d_r && !SCAN_IN && high_cnt_r < SCANC) begin
            high_ok_r <= 1'b0;
         end
         if (st_nxt == ST_BLANK && st_r != ST_BLANK) begin
            tmr_r <= BLANK_LD;
         end else if (st_r == ST_BLANK && SCAN_EXT_EN && !SCAN_IN) begin
            tmr_r <= BLANK_LD; // low time adds to the fixed gap
         end else if (st_nxt == ST_STROBE && st_r != ST_STROBE) begin
            tmr_r <= RAMP;
         end else if (tmr_r != 16'h0000) begin
            tmr_r <= tmr_r - 16'h0001;
         end
         if (SCAN_SET) begin
            slot_r <= `BCS_DIG6;
         end else if (strobe_fall) begin
            // 6 down to 1, then wrap
            slot_r <= slot_r[0] ? `BCS_DIG6 : (slot_r >> 1);
         end
      end
   end

   // strobes gated by blanking; one-hot slot keeps them exclusive
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DIGIT <= {NDIG{1'b0}};
         BLANKING <= 1'b1;
      end else begin
         DIGIT <= (st_nxt == ST_STROBE) ? slot_r : {NDIG{1'b0}};
         BLANKING <= (st_nxt != ST_STROBE);
      end
   end

   // precharge: inputs read as zero outside a strobe
   always @* begin
      sel_cnt = (st_r == ST_STROBE) ? CNT_BCD : 4'h0;
      sel_reg = (st_r == ST_STROBE) ? REG_BCD : 4'h0;
   end

   // preset requests latched in blanking, dropped only at next blanking
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ld_cnt_r <= 1'b0;
         ld_reg_r <= 1'b0;
      end else if (st_r != ST_STROBE) begin
         ld_cnt_r <= LOAD_CNT;
         ld_reg_r <= LOAD_REG;
      end
   end

   // register store; independent of counter preset
   bcs_store #(.NDIG(NDIG)) u_reg (
      .CLK(CLK),
      .RST_N(RST_N),
      .ld(strobe_fall & ld_reg_r),
      .ld_sel(slot_r),
      .ld_data(sel_reg),
      .q(reg_val)
   );

   // count edge detect, minimum spacing bounds the 1 MHz rate
   assign count_edge = COUNT & ~count_d_r & (gap_r == 16'h0000);
   assign clr_now = (clr_cnt_r >= CLR_CYC);
   assign cnt_frozen = COUNT_HOLD | ld_cnt_r;

   always @* begin
      nxt_val = COUNT_VAL;
      c = 1'b1;
      s = 5'h00;
      for (i = 0; i < NDIG; i = i + 1) begin
         s = bcd_step(COUNT_VAL[4*i +: 4], UP_DN);
         if (c) begin
            nxt_val[4*i +: 4] = s[3:0];
         end
         c = c & s[4];
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         COUNT_VAL <= `BCS_RST_VALUE;
         count_d_r <= 1'b0;
         gap_r <= 16'h0000;
         clr_cnt_r <= 16'h0000;
         CARRY <= 1'b0;
      end else begin
         count_d_r <= COUNT;
         if (count_edge) begin
            gap_r <= CNT_MIN - 16'h0001;
         end else if (gap_r != 16'h0000) begin
            gap_r <= gap_r - 16'h0001;
         end
         clr_cnt_r <= CLEAR ? (clr_now ? clr_cnt_r : clr_cnt_r + 16'h0001) : 16'h0000;
         CARRY <= 1'b0;
         if (clr_now) begin
            COUNT_VAL <= {(4*NDIG){1'b0}};
         end else if (strobe_fall && ld_cnt_r) begin
            for (j = 0; j < NDIG; j = j + 1) begin
               if (slot_r[j]) begin
                  COUNT_VAL[4*j +: 4] <= sel_cnt;
               end
            end
         end else if (count_edge && !cnt_frozen) begin
            COUNT_VAL <= nxt_val;
            CARRY <= c;
         end
      end
   end

   // match registered at once; zero goes through an extra delay line
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         MATCH <= 1'b0;
         ZERO <= 1'b0;
         zero_sh_r <= 4'h0;
      end else begin
         // suppressed during counter preset; a preset changes the value and so frees the hold
         MATCH <= ~ld_cnt_r & (COUNT_VAL == reg_val);
         zero_sh_r <= {zero_sh_r[2:0], ~ld_cnt_r & (COUNT_VAL == {(4*NDIG){1'b0}})};
         ZERO <= zero_sh_r[`BCS_ZERO_DLY-1] & ~ld_cnt_r;
      end
   end

   // store latch and digit readout, most significant first
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         latch_r <= {(4*NDIG){1'b0}};
         lead_r <= {NDIG{1'b1}};
         BCD_OUT <= 4'h0;
         BCD_OUT_BLANK <= 1'b0;
      end else begin
         if (!STORE) begin
            latch_r <= COUNT_VAL;
         end
         // leading_blank flags: digit is zero and all higher ones are too; digit 1 is never flagged
         lead_r[NDIG-1] <= (latch_r[4*NDIG-1 -: 4] == 4'h0);
         for (k = NDIG - 2; k >= 0; k = k - 1) begin
            lead_r[k] <= lead_r[k+1] & (latch_r[4*k +: 4] == 4'h0) & (k != 0);
         end
         BCD_OUT <= 4'h0;
         BCD_OUT_BLANK <= 1'b1;
         for (k = 0; k < NDIG; k = k + 1) begin
            if (slot_r[k] && st_nxt == ST_STROBE) begin
               BCD_OUT <= latch_r[4*k +: 4];
               BCD_OUT_BLANK <= ~LEADING_BLANK_CTRL & lead_r[k];
            end
         end
      end
   end
endmodule // bcs_counter
`default_nettype wire

// >>> bcs_sw_model.sv
// switch matrix model feeding the preset bcd inputs
`timescale 1ns/1ps
`default_nettype none
module bcs_sw_model (
   // strobes and switch settings
   input wire logic [5:0] digit,
   input wire logic [23:0] cnt_sw,
   input wire logic [23:0] reg_sw,
   input wire logic share,
   // matrix outputs
   output logic [3:0] cnt_bcd,
   output logic [3:0] reg_bcd
);
   logic [3:0] c;
   logic [3:0] r;
   always_comb begin
      c = 4'h0; // precharge holds lines low between strobes
      r = 4'h0;
      for (int i = 0; i < 6; i++) begin
         if (digit[i]) begin
            c = cnt_sw[4*i +: 4]; // strobe i+1 enables decade i switch
            r = reg_sw[4*i +: 4];
         end
      end
   end
   assign cnt_bcd = c;
   assign reg_bcd = share ? c : r; // one matrix may feed both inputs
endmodule // bcs_sw_model
`default_nettype wire

// >>> bcs_counter_props.sv
// checker for the scan-preset bcd counter
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.vh"
module bcs_counter_props #(parameter NDIG = 6) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // scan
   input wire logic SCAN_EXT_EN,
   input wire logic SCAN_IN,
   input wire logic [NDIG-1:0] DIGIT,
   input wire logic BLANKING,
   // counting
   input wire logic COUNT_HOLD,
   input wire logic CLEAR,
   input wire logic [4*NDIG-1:0] COUNT_VAL,
   input wire logic ZERO,
   input wire logic CARRY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic [8:0] blk_r;
   logic [NDIG-1:0] last_r;
   logic int_r;
   logic ext_r;
   logic [15:0] hi_r;
   logic bad;
   // ext_r: a full low seen under external drive, so the gap timer was reloaded
   // int_r: first gap after leaving external drive has no fixed length
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         blk_r <= 9'h000;
         last_r <= '0;
         int_r <= 1'b0;
         ext_r <= 1'b0;
         hi_r <= 16'h0000;
      end else begin
         ext_r <= SCAN_EXT_EN && (ext_r || !SCAN_IN);
         hi_r <= (SCAN_EXT_EN && SCAN_IN) ? hi_r + 16'h0001 : 16'h0000;
         blk_r <= BLANKING ? blk_r + 9'h001 : 9'h000;
         last_r <= (|DIGIT) ? DIGIT : last_r;
         int_r <= !SCAN_EXT_EN && (int_r || (|DIGIT));
      end
   end
   always_comb begin
      bad = 1'b0;
      for (int i = 0; i < NDIG; i++)
         bad = bad | (COUNT_VAL[4*i +: 4] > 4'h9);
   end
   sequence s_ext_low;
      SCAN_EXT_EN && !SCAN_IN ##1 SCAN_EXT_EN && !SCAN_IN;
   endsequence
   property p_one; $onehot0(DIGIT); endproperty
   a_one: assert property (p_one) else $error("two strobes on");
   property p_dark; BLANKING |-> DIGIT == '0; endproperty
   a_dark: assert property (p_dark) else $error("strobe in gap");
   property p_blank; $fell(BLANKING) && int_r && !SCAN_EXT_EN |-> blk_r == `BCS_BLANK_CYC; endproperty
   a_blank: assert property (p_blank) else $error("gap length");
   property p_order; $rose(|DIGIT) && int_r |-> DIGIT == (last_r[0] ? {1'b1, {NDIG-1{1'b0}}} : last_r >> 1); endproperty
   a_order: assert property (p_order) else $error("scan order");
   property p_hold; BLANKING && COUNT_HOLD && !CLEAR |=> $stable(COUNT_VAL); endproperty
   a_hold: assert property (p_hold) else $error("counted in hold");
   property p_legal; !bad; endproperty
   a_legal: assert property (p_legal) else $error("decade above 9");
   property p_wrap; CARRY |-> COUNT_VAL == '0 || COUNT_VAL == {NDIG{4'h9}}; endproperty
   a_wrap: assert property (p_wrap) else $error("carry without wrap");
   property p_pulse; CARRY |=> !CARRY; endproperty
   a_pulse: assert property (p_pulse) else $error("carry too long");
   property p_zero; $rose(ZERO) |-> COUNT_VAL == '0 && $past(COUNT_VAL, 4) == '0; endproperty
   a_zero: assert property (p_zero) else $error("zero too early");
   property p_ext; s_ext_low |-> DIGIT == '0; endproperty
   a_ext: assert property (p_ext) else $error("strobe while scan low");
   property p_extgap; $rose(|DIGIT) && ext_r |-> hi_r == `BCS_BLANK_CYC; endproperty
   a_extgap: assert property (p_extgap) else $error("external gap length");
endmodule // bcs_counter_props
bind bcs_counter bcs_counter_props #(.NDIG(NDIG)) u_props (.CLK, .RST_N, .SCAN_EXT_EN, .SCAN_IN, .DIGIT,
   .BLANKING, .COUNT_HOLD, .CLEAR, .COUNT_VAL, .ZERO, .CARRY);
`default_nettype wire

// >>> bcd_counter_scan_preset_tb_top.sv
// self-checking bench for the scan-preset bcd counter
`timescale 1ns/1ps
`default_nettype none
module bcd_counter_scan_preset_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ext_en = 1'b0;
   logic scan_in = 1'b0;
   logic load_cnt = 1'b0;
   logic load_reg = 1'b0;
   logic count = 1'b0;
   logic up_dn = 1'b0;
   logic fb = 1'b0;
   logic clear = 1'b0;
   logic share = 1'b0;
   logic lz = 1'b1;
   wire logic [3:0] bcd_out;
   wire logic bcd_blank;
   logic [23:0] cnt_sw = 24'h000000;
   logic [23:0] reg_sw = 24'h000000;
   wire logic [5:0] digit;
   wire logic [3:0] cnt_bcd;
   wire logic [3:0] reg_bcd;
   wire logic [23:0] count_val;
   wire logic blanking;
   wire logic match;
   wire logic zero;
   wire logic carry;
   int fail_count = 0;
   int n_compared = 0;
   int dig_seen = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) dig_seen += (|digit);
   // short slot and external-high limits keep the run brief
   bcs_counter #(.RAMP_CYC(10), .SCANC_CYC(20)) dut (.CLK(clk), .RST_N(rst_n), .SCAN_EXT_EN(ext_en),
      .SCAN_IN(scan_in), .SCAN_SET(1'b0), .DIGIT(digit), .BLANKING(blanking), .CNT_BCD(cnt_bcd),
      .REG_BCD(reg_bcd), .LOAD_CNT(load_cnt), .LOAD_REG(load_reg), .COUNT(count), .UP_DN(up_dn),
      .COUNT_HOLD(fb & match), .CLEAR(clear), .STORE(1'b0), .LEADING_BLANK_CTRL(lz),
      .COUNT_VAL(count_val), .BCD_OUT(bcd_out), .BCD_OUT_BLANK(bcd_blank), .MATCH(match),
      .ZERO(zero), .CARRY(carry));
   bcs_sw_model sw (.digit(digit), .cnt_sw(cnt_sw), .reg_sw(reg_sw), .share(share), .cnt_bcd(cnt_bcd),
      .reg_bcd(reg_bcd));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // readout digit k+1 seen mid-strobe as {blank, bcd}
   task automatic chk_out(input int k, input logic [4:0] exp);
      do @(negedge clk); while (!digit[k]);
      chk({bcd_blank, bcd_out}, exp);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_d1;
      repeat (1200) begin
         @(posedge clk);
         if (digit[0])
            break;
      end
      while (digit[0])
         @(posedge clk);
   endtask
   task automatic do_load(input logic [23:0] c, input logic [23:0] r, input logic lc, input logic lr);
      cnt_sw <= c;
      reg_sw <= r;
      wait_d1;
      load_cnt <= lc; // raised in a gap, held two full scans
      load_reg <= lr;
      wait_d1;
      wait_d1;
      load_cnt <= 1'b0;
      load_reg <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic pulse(input int n, input logic up);
      up_dn <= up;
      repeat (n) begin
         @(posedge clk);
         count <= 1'b1; // one edge per 40 cycles, the top rate
         repeat (20) @(posedge clk);
         count <= 1'b0;
         repeat (19) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic scan(input int hi);
      repeat (8) begin
         scan_in <= 1'b1;
         repeat (hi) @(posedge clk);
         scan_in <= 1'b0; // low time kept above 2 us
         repeat (100) @(posedge clk);
      end
   endtask
   task automatic t_preset;
      do_load(24'h907312, 24'h907307, 1'b1, 1'b1);
      chk(count_val, 24'h907312);
      chk(match, 1'b0);
      pulse(5, 1'b0);
      chk(count_val, 24'h907307);
      chk(match, 1'b1);
      share <= 1'b1;
      do_load(24'h000012, 24'h000000, 1'b1, 1'b1);
      chk(count_val, 24'h000012);
      chk(match, 1'b1);
      lz <= 1'b0;
      chk_out(5, 5'h10);
      chk_out(1, 5'h01);
      chk_out(0, 5'h02);
      lz <= 1'b1;
      share <= 1'b0;
      $display("preset done");
   endtask
   task automatic t_zero;
      do_load(24'h000012, 24'h000002, 1'b0, 1'b1);
      pulse(10, 1'b0);
      chk(match, 1'b1);
      chk(zero, 1'b0);
      pulse(2, 1'b0);
      chk(zero, 1'b1);
      do_load(24'h000001, 24'h000000, 1'b1, 1'b1);
      count <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(match, 1'b1);
      chk(zero, 1'b0);
      repeat (6) @(posedge clk);
      chk(zero, 1'b1);
      count <= 1'b0;
      // next edge must clear the minimum count spacing
      repeat (40) @(posedge clk);
      pulse(1, 1'b0);
      chk(count_val, 24'h999999);
      pulse(1, 1'b1);
      chk(count_val, 24'h000000);
      $display("zero done");
   endtask
   task automatic t_freeze;
      do_load(24'h000006, 24'h000003, 1'b1, 1'b1);
      fb <= 1'b1;
      pulse(6, 1'b0);
      chk(count_val, 24'h000003);
      do_load(24'h000006, 24'h000001, 1'b0, 1'b1);
      pulse(4, 1'b0);
      chk(count_val, 24'h000001);
      clear <= 1'b1;
      repeat (100) @(posedge clk);
      clear <= 1'b0;
      pulse(1, 1'b1);
      chk(count_val, 24'h000001);
      fb <= 1'b0;
      $display("freeze done");
   endtask
   task automatic t_ext;
      ext_en <= 1'b1;
      dig_seen = 0;
      scan(200);
      chk(dig_seen > 0, 1'b1);
      scan(5);
      dig_seen = 0;
      scan(200);
      chk(dig_seen, 24'h000000);
      $display("external scan done");
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t watchdog", $time);
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_preset;
      t_zero;
      t_freeze;
      t_ext;
      stop_test;
   end
endmodule // bcd_counter_scan_preset_tb_top
`default_nettype wire
